// >>> rtl/gdl_regs.svh
`ifndef GDL_REGS_SVH
`define GDL_REGS_SVH

// register indices; byte address is four times the index
`define GDL_IDX_DRV_CTRL 8'h02
`define GDL_IDX_GATE_HS 8'h03
`define GDL_ADDR_DRV_CTRL 8'h08
`define GDL_ADDR_GATE_HS 8'h0C

// gate drive high-side field positions
`define GDL_LOCK_HI 10
`define GDL_LOCK_LO 8
`define GDL_SRC_HI 7
`define GDL_SRC_LO 4
`define GDL_SINK_HI 3
`define GDL_SINK_LO 0

// driver control field positions
`define GDL_CLR_BIT 0
`define GDL_BRAKE_BIT 1
`define GDL_COAST_BIT 2

// lock patterns and reset values
`define GDL_LOCK_OPEN 3'h3
`define GDL_LOCK_SHUT 3'h6
`define GDL_CODE_RST 4'hF
`define GDL_DRV_RST 11'h000

// peak current scaling: sink table is the source table doubled
`define GDL_SRC_SHIFT 0
`define GDL_SINK_SHIFT 1

`endif

// >>> rtl/gdl_pkg.sv
package gdl_pkg;

  typedef enum logic [1:0] {
    GDL_ST_UNLOCKED = 2'b01,
    GDL_ST_LOCKED = 2'b10
  } gdl_lock_state_t;

  typedef logic [3:0] gdl_code_t;
  typedef logic [11:0] gdl_milliamp_t;

endpackage

// >>> rtl/gdl_current_lut.sv
`timescale 1ns/1ps
`include "gdl_regs.svh"

module gdl_current_lut import gdl_pkg::*; #(
  parameter int SHIFT = 0
) (
  input wire logic clk,
  input wire logic reset,
  input wire gdl_code_t code,
  output gdl_milliamp_t milliAmp
);

  // ==========================================================
  // source table in mA; the sink table is exactly twice it
  gdl_milliamp_t base;
  gdl_milliamp_t milliAmp_q;

  always_comb begin
    case (code)
      4'h0, 4'h1: base = 12'h032;
      4'h2: base = 12'h064;
      4'h3: base = 12'h096;
      4'h4: base = 12'h12C;
      4'h5: base = 12'h15E;
      4'h6: base = 12'h190;
      4'h7: base = 12'h1C2;
      4'h8: base = 12'h226;
      4'h9: base = 12'h258;
      4'hA: base = 12'h28A;
      4'hB: base = 12'h2BC;
      4'hC: base = 12'h352;
      4'hD: base = 12'h384;
      4'hE: base = 12'h3B6;
      default: base = 12'h3E8;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      milliAmp_q <= 12'h000;
    end else begin
      milliAmp_q <= base << SHIFT;
    end
  end

  assign milliAmp = milliAmp_q;

  // ==========================================================
  // checks
  property p_lut_top;
    @(posedge clk) disable iff (reset)
      code == 4'hF |=> milliAmp == (12'h3E8 << SHIFT);
  endproperty
  a_lut_top: assert property (p_lut_top)
    else $error("top code gives wrong peak current");

  property p_lut_low;
    @(posedge clk) disable iff (reset)
      code <= 4'h1 |=> milliAmp == (12'h032 << SHIFT);
  endproperty
  a_lut_low: assert property (p_lut_low)
    else $error("lowest codes give wrong peak current");

endmodule

// >>> rtl/gdl_lock_reg.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "gdl_regs.svh"


module gdl_lock_reg import gdl_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic locked,
  output gdl_code_t highSideSourceCurrentCode,
  output gdl_code_t highSideSinkCurrentCode,
  output gdl_milliamp_t sourceCurrentMa,
  output gdl_milliamp_t sinkCurrentMa,
  output logic [10:0] driverControl,
  output logic faultClearStrobe,
  output logic brake,
  output logic coast
);

  // ==========================================================
  // bus handshake: one wait cycle, then the access completes
  logic waitReq_q;
  logic [31:0] readData_q;
  logic wrAcc;
  logic rdAcc;
  logic hsSel;
  logic drvSel;

  assign wrAcc = write && !waitReq_q;
  assign rdAcc = read && waitReq_q;
  assign hsSel = address == `GDL_ADDR_GATE_HS;
  assign drvSel = address == `GDL_ADDR_DRV_CTRL;

  always_ff @(posedge clk) begin
    if (reset) begin
      waitReq_q <= 1'b1;
    end else if ((read || write) && waitReq_q) begin
      waitReq_q <= 1'b0;
    end else begin
      waitReq_q <= 1'b1;
    end
  end

  // ==========================================================
  // lock state
  gdl_lock_state_t state_q;
  logic [2:0] lockField;
  logic [2:0] lockWr;

  assign lockField = (state_q == GDL_ST_LOCKED) ? `GDL_LOCK_SHUT
                                                : `GDL_LOCK_OPEN;
  assign lockWr = writedata[`GDL_LOCK_HI:`GDL_LOCK_LO];

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= GDL_ST_UNLOCKED;
    end else if (wrAcc && hsSel && byteenable[1]) begin
      case (state_q)
        GDL_ST_UNLOCKED: begin
          if (lockWr == `GDL_LOCK_SHUT) begin
            state_q <= GDL_ST_LOCKED;
          end
        end
        GDL_ST_LOCKED: begin
          if (lockWr == `GDL_LOCK_OPEN) begin
            state_q <= GDL_ST_UNLOCKED;
          end
        end
        default: state_q <= GDL_ST_UNLOCKED;
      endcase
    end
  end

  // ==========================================================
  // high-side current codes, frozen while locked
  gdl_code_t srcCode_q;
  gdl_code_t sinkCode_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      srcCode_q <= `GDL_CODE_RST;
      sinkCode_q <= `GDL_CODE_RST;
    end else if (wrAcc && hsSel && byteenable[0]
                 && state_q == GDL_ST_UNLOCKED) begin
      srcCode_q <= writedata[`GDL_SRC_HI:`GDL_SRC_LO];
      sinkCode_q <= writedata[`GDL_SINK_HI:`GDL_SINK_LO];
    end
  end

  // ==========================================================
  // driver control: low three bits bypass the lock
  logic [10:0] drvCtrl_q;
  logic drvUnl;

  assign drvUnl = state_q == GDL_ST_UNLOCKED;

  always_ff @(posedge clk) begin
    if (reset) begin
      drvCtrl_q <= `GDL_DRV_RST;
    end else begin
      // fault clear is a strobe: it drops the cycle after it is set
      drvCtrl_q[`GDL_CLR_BIT] <= 1'b0;
      if (wrAcc && drvSel && byteenable[0]) begin
        drvCtrl_q[2:0] <= writedata[2:0];
        if (drvUnl) begin
          drvCtrl_q[7:3] <= writedata[7:3];
        end
      end
      if (wrAcc && drvSel && byteenable[1] && drvUnl) begin
        drvCtrl_q[10:8] <= writedata[10:8];
      end
    end
  end

  // ==========================================================
  // read path; unmapped addresses read as zero
  always_ff @(posedge clk) begin
    if (reset) begin
      readData_q <= 32'h0000_0000;
    end else if (rdAcc) begin
      if (hsSel) begin
        readData_q <= {21'h0, lockField, srcCode_q,
                       sinkCode_q};
      end else if (drvSel) begin
        readData_q <= {21'h0, drvCtrl_q};
      end else begin
        readData_q <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // peak current decode, registered for the drive stage
  gdl_current_lut #(.SHIFT(`GDL_SRC_SHIFT)) srcLut (
    .clk(clk),
    .reset(reset),
    .code(srcCode_q),
    .milliAmp(sourceCurrentMa)
  );

  gdl_current_lut #(.SHIFT(`GDL_SINK_SHIFT)) sinkLut (
    .clk(clk),
    .reset(reset),
    .code(sinkCode_q),
    .milliAmp(sinkCurrentMa)
  );

  assign readdata = readData_q;
  assign waitrequest = waitReq_q;
  // one-hot state: bit 1 is the locked code, so no decode after the flop
  assign locked = state_q[1];
  assign highSideSourceCurrentCode = srcCode_q;
  assign highSideSinkCurrentCode = sinkCode_q;
  assign driverControl = drvCtrl_q;
  assign faultClearStrobe = drvCtrl_q[`GDL_CLR_BIT];
  assign brake = drvCtrl_q[`GDL_BRAKE_BIT];
  assign coast = drvCtrl_q[`GDL_COAST_BIT];

  // ==========================================================
  // checks
  property p_reset_vals;
    @(posedge clk) reset |=> srcCode_q == 4'hF && sinkCode_q == 4'hF
                            && lockField == 3'h3;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");

  property p_codes_store;
    @(posedge clk) disable iff (reset)
      wrAcc && hsSel && byteenable[0] && !locked
      |=> srcCode_q == $past(writedata[7:4])
          && sinkCode_q == $past(writedata[3:0]);
  endproperty
  a_codes_store: assert property (p_codes_store)
    else $error("unlocked code write not stored");

  property p_lock_enter;
    @(posedge clk) disable iff (reset)
      wrAcc && hsSel && byteenable[1] && writedata[10:8] == 3'h6
      |=> locked;
  endproperty
  a_lock_enter: assert property (p_lock_enter)
    else $error("lock pattern did not lock");

  property p_locked_frozen;
    @(posedge clk) disable iff (reset)
      locked ##1 locked |-> $stable(srcCode_q) && $stable(sinkCode_q)
                            && $stable(drvCtrl_q[10:3]);
  endproperty
  a_locked_frozen: assert property (p_locked_frozen)
    else $error("locked field changed");

  property p_low_bits_open;
    @(posedge clk) disable iff (reset)
      locked && wrAcc && drvSel && byteenable[0]
      |=> drvCtrl_q[2:1] == $past(writedata[2:1]);
  endproperty
  a_low_bits_open: assert property (p_low_bits_open)
    else $error("brake or coast write lost while locked");

  property p_unlocked_stays;
    @(posedge clk) disable iff (reset)
      !locked && !(wrAcc && hsSel && byteenable[1]
                   && writedata[10:8] == 3'h6) |=> !locked;
  endproperty
  a_unlocked_stays: assert property (p_unlocked_stays)
    else $error("locked without the lock pattern");

  property p_unlock;
    @(posedge clk) disable iff (reset)
      locked && wrAcc && hsSel && byteenable[1]
      && writedata[10:8] == 3'h3 |=> !locked;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock pattern ignored");

  property p_strobe_pulse;
    @(posedge clk) disable iff (reset)
      faultClearStrobe |=> !faultClearStrobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("fault clear did not self clear");

  property p_read_lock;
    @(posedge clk) disable iff (reset)
      rdAcc && hsSel |=> !waitrequest && readdata[10:8] == lockField
                         && readdata[7:0] == {srcCode_q, sinkCode_q};
  endproperty
  a_read_lock: assert property (p_read_lock)
    else $error("read data does not match stored fields");

  c_lock: cover property (@(posedge clk) disable iff (reset)
    !locked ##1 locked);
  c_unlock: cover property (@(posedge clk) disable iff (reset)
    locked ##1 !locked);
  c_brake_locked: cover property (@(posedge clk) disable iff (reset)
    locked && brake);

endmodule

// >>> sim/gdl_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// bus master standing in for the external motor controller
module gdl_host_model (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
  end

  // request held until waitrequest is seen low; no latency assumed,
  // a hung slave is cut short by the bench watchdog
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// >>> sim/gdl_lock_reg_tb.sv
`timescale 1ns/1ps
`include "gdl_regs.svh"
module gdl_lock_reg_tb import gdl_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address;
  logic read, write, waitrequest, locked, brake, coast, faultClearStrobe;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  gdl_code_t srcCode, sinkCode;
  gdl_milliamp_t srcMa, sinkMa;
  logic [10:0] driverControl;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  int nStrobe = 0;
  int strobeBase;
  // peak source mA per code: 50,50,100,150,300..450,550..700,850..1000
  logic [11:0] srcTab [16] = '{12'h032, 12'h032, 12'h064, 12'h096,
    12'h12C, 12'h15E, 12'h190, 12'h1C2, 12'h226, 12'h258, 12'h28A,
    12'h2BC, 12'h352, 12'h384, 12'h3B6, 12'h3E8};

  always #2 clk = ~clk;

  gdl_host_model host (.clk(clk), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable));

  gdl_lock_reg dut (.clk(clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .locked(locked),
    .highSideSourceCurrentCode(srcCode),
    .highSideSinkCurrentCode(sinkCode), .sourceCurrentMa(srcMa),
    .sinkCurrentMa(sinkMa), .driverControl(driverControl),
    .faultClearStrobe(faultClearStrobe), .brake(brake), .coast(coast));

  // ==========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, 4'hF, q);
  endtask

  // single-lane write: lane 0 carries the codes, lane 1 the lock field
  task automatic wrBe(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    host.xfer(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, 4'hF, q);
    check(q, exp);
  endtask

  // strobe counted per cycle so a stuck-high strobe shows as extra counts
  always @(posedge clk) begin
    cycles++;
    if (faultClearStrobe === 1'b1) nStrobe++;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(`GDL_ADDR_GATE_HS, 32'h3FF);
    check(locked, 1'b0);
    check(srcMa, 32'h3E8);
    check(sinkMa, 32'h7D0);
    rd(`GDL_ADDR_DRV_CTRL, 32'h000);
    rd(8'h10, 32'h0);
    for (int i = 0; i < 16; i++) begin
      wr(`GDL_ADDR_GATE_HS, {21'h0, 3'h3, i[3:0], i[3:0]});
      repeat (2) @(posedge clk);
      check(srcCode, i);
      check(sinkCode, i);
      check(srcMa, srcTab[i]);
      check(sinkMa, {srcTab[i], 1'b0});
    end
    // lane 0 alone stores codes and leaves the lock field untouched
    wrBe(`GDL_ADDR_GATE_HS, 32'h600, 4'h1);
    rd(`GDL_ADDR_GATE_HS, 32'h300);
    check(locked, 1'b0);
    // lane 1 alone locks and leaves the codes untouched
    wrBe(`GDL_ADDR_GATE_HS, 32'h6AA, 4'h2);
    rd(`GDL_ADDR_GATE_HS, 32'h600);
    check(locked, 1'b1);
    wr(`GDL_ADDR_GATE_HS, 32'h3FF);
    rd(`GDL_ADDR_GATE_HS, 32'h300);
    check(locked, 1'b0);
    // unlocked: a lock value other than the locking one leaves it unlocked; the codes still store
    wr(`GDL_ADDR_GATE_HS, 32'h077);
    rd(`GDL_ADDR_GATE_HS, 32'h377);
    check(locked, 1'b0);
    // lock, with new codes in the same write
    wr(`GDL_ADDR_GATE_HS, 32'h655);
    rd(`GDL_ADDR_GATE_HS, 32'h655);
    check(locked, 1'b1);
    // locked: wrong unlock pattern and new codes are both dropped
    wr(`GDL_ADDR_GATE_HS, 32'h500);
    rd(`GDL_ADDR_GATE_HS, 32'h655);
    check(locked, 1'b1);
    // locked: only driver control bits 0-2 land
    strobeBase = nStrobe;
    wr(`GDL_ADDR_DRV_CTRL, 32'h7FF);
    rd(`GDL_ADDR_DRV_CTRL, 32'h006);
    check(nStrobe - strobeBase, 1);
    check(driverControl, 32'h006);
    check(brake, 1'b1);
    check(coast, 1'b1);
    // unlock; codes in the unlocking write are still dropped
    wr(`GDL_ADDR_GATE_HS, 32'h3AA);
    rd(`GDL_ADDR_GATE_HS, 32'h355);
    check(locked, 1'b0);
    wr(`GDL_ADDR_GATE_HS, 32'h3AA);
    rd(`GDL_ADDR_GATE_HS, 32'h3AA);
    wr(`GDL_ADDR_DRV_CTRL, 32'h7F8);
    rd(`GDL_ADDR_DRV_CTRL, 32'h7F8);
    check(driverControl, 32'h7F8);
    check({brake, coast}, 2'b00);
    conclude();
  end
endmodule
